// ---- mbc_memory_bank_controller.sv ----
/*
  mbc_memory_bank_controller: eight-bank external memory controller with
  static and programmable-pattern DRAM access, refresh and bus sizing.
  Assumes a synchronous external bus on clk; resetn is the hard reset.
*/
// Summary of operation
// R1 - up to eight banks, one select each
// R2 - static access takes at least two clocks
// R3 - block size 32 KB to 256 MB
// R4 - zero to fifteen wait states per bank
// R5 - optional address type match per bank
// R6 - four byte enables plus one output enable
// R7 - boot select live straight out of reset
// R8 - DRAM ports 8, 16 and 32 bits
// R9 - DRAM timing from software pattern table
// R10 - DRAM depths 64 KB to 256 MB
// R11 - small depths byte only, huge word only
// R12 - burst beats use page mode, row open
// R13 - CAS-before-RAS refresh from programmable timer
// R14 - refresh continues during external reset
// R15 - refresh can be switched off
// R16 - up to seven refreshes stacked
// R17 - dynamic bus sizing splits transfers
// R18 - big, little and modified little endian
// R19 - configuration cleared by hard reset only
// R20 - soft reset keeps configuration
// R21 - lowest matching bank wins
`timescale 1ns/1ns
`default_nettype none
module mbc_memory_bank_controller (
  input  wire logic                   clk,
  input  wire logic                   resetn,
  input  wire logic                   soft_resetn,
  input  wire logic [1:0]             boot_port,
  input  wire logic                   cfg_we,
  input  wire logic [2:0]             cfg_bank,
  input  wire mbc_pkg::mbc_bank_cfg_t cfg_data,
  input  wire logic                   pat_we,
  input  wire logic [4:0]             pat_addr,
  input  wire mbc_pkg::mbc_pat_t      pat_data,
  input  wire logic [1:0]             endian,
  input  wire logic                   ref_en,
  input  wire logic [15:0]            ref_period,
  input  wire logic                   bus_req,
  input  wire mbc_pkg::mbc_bus_req_t  bus_cmd,
  input  wire logic [31:0]            bus_wdata,
  output logic                        bus_ready,
  output logic                        bus_ack,
  output logic                        bus_err,
  output logic [31:0]                 bus_rdata,
  output logic [31:0]                 mem_addr,
  output logic [7:0]                  mem_cs_n,
  output logic [3:0]                  mem_be_n,
  output logic                        mem_oe_n,
  output logic                        mem_we_n,
  output logic                        mem_ras_n,
  output logic                        mem_cas_n,
  output logic [31:0]                 mem_d_o,
  output logic                        mem_d_oe_n,
  input  wire logic [31:0]            mem_d_i,
  output logic [2:0]                  ref_pending
);
  mbc_pkg::mbc_bank_cfg_t cfg_reg [mbc_pkg::NBANK];
  mbc_pkg::mbc_bank_cfg_t cfg_next [mbc_pkg::NBANK];
  mbc_pkg::mbc_pat_t      pat_reg [mbc_pkg::PAT_DEPTH];
  mbc_pkg::mbc_pat_t      pat_next [mbc_pkg::PAT_DEPTH];
  mbc_pkg::mbc_state_t    state_reg, state_next;
  mbc_pkg::mbc_bus_req_t  cmd_reg, cmd_next;
  mbc_pkg::mbc_bank_cfg_t scfg_reg, scfg_next;
  mbc_pkg::mbc_pat_t      pat_cur;
  logic [2:0]  sel_reg, sel_next, hit_idx;
  logic        any_hit, take, ref_req, ref_done, sub_done, wack;
  logic [31:0] cur_reg, cur_next;
  logic [4:0]  left_reg, left_next, nbytes;
  logic [3:0]  wcnt_reg, wcnt_next;
  logic [4:0]  ptr_reg, ptr_next;
  logic        page_reg, page_next, beat_end;
  logic        samp_reg, samp_next, send_reg, send_next;
  logic [1:0]  sa_reg, sa_next;
  logic [4:0]  sn_reg, sn_next;
  logic [31:0] acc_next;
  logic        ack_reg, ack_next, err_reg, err_next;
  logic [31:0] addr_next, d_o_next;
  logic [7:0]  cs_n_next;
  logic [3:0]  be_n_next;
  logic        oe_n_next, we_n_next, ras_n_next, cas_n_next, d_oe_n_next;
  logic        ref_act_reg, ref_act_next;
  logic [1:0]  ab, bl, ml;

  function automatic logic f_hit(mbc_pkg::mbc_bank_cfg_t c,
                                 logic [31:0] a, logic [2:0] t);
    logic [31:0] m;
    logic        ok;
    m = 32'hFFFF_FFFF << (mbc_pkg::BLK_SHIFT + int'(c.size)); // R3
    ok = c.valid && c.size <= mbc_pkg::SZ_MAX
      && c.port <= mbc_pkg::PORT_32; // R8
    if (c.dram)
      ok = ok && c.size >= mbc_pkg::SZ_DRAM_MIN // R10
        && (c.size > mbc_pkg::SZ_BYTE_ONLY || c.port == mbc_pkg::PORT_8)
        && (c.size < mbc_pkg::SZ_WORD_ONLY
            || c.port == mbc_pkg::PORT_32); // R11
    if (c.atype_en && c.atype != t)
      ok = 1'b0; // R5
    return ok && (((a ^ {c.base, 15'h0000}) & m) == 32'h0000_0000);
  endfunction

  // bus byte lane of an address; modified little endian is pre-munged
  function automatic logic [1:0] f_lane(logic [1:0] a, logic [1:0] e);
    return (e == mbc_pkg::END_LITTLE) ? ~a : a; // R18
  endfunction

  function automatic logic [1:0] f_mlane(logic [1:0] a, logic [1:0] p,
                                         logic [1:0] e);
    if (p == mbc_pkg::PORT_32)
      return f_lane(a, e);
    else if (p == mbc_pkg::PORT_16)
      return {1'b0, a[0] ^ (e == mbc_pkg::END_LITTLE)};
    return 2'h0;
  endfunction

  function automatic logic [4:0] f_pbytes(logic [1:0] p);
    return (p == mbc_pkg::PORT_32) ? 5'h04
         : (p == mbc_pkg::PORT_16) ? 5'h02 : 5'h01;
  endfunction

  mbc_refresh_timer u_refresh (
    .clk         (clk),
    .resetn      (resetn),
    .ref_en      (ref_en),
    .ref_period  (ref_period),
    .ref_done    (ref_done),
    .ref_req     (ref_req),
    .ref_pending (ref_pending)
  );

  // configuration and pattern table
  always_comb
  begin
    cfg_next = cfg_reg;
    pat_next = pat_reg;
    if (cfg_we)
      cfg_next[cfg_bank] = cfg_data;
    if (pat_we)
      pat_next[pat_addr] = pat_data; // R9
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < mbc_pkg::NBANK; i++)
        cfg_reg[i] <= mbc_pkg::CFG_RST; // R19
      cfg_reg[0] <= '{valid: 1'b1, base: mbc_pkg::BOOT_BASE,
                      size: mbc_pkg::SZ_MAX, waits: mbc_pkg::BOOT_WAITS,
                      atype_en: 1'b0, atype: 3'h0, port: boot_port,
                      dram: 1'b0}; // R7
      for (int i = 0; i < mbc_pkg::PAT_DEPTH; i++)
        pat_reg[i] <= mbc_pkg::PAT_RST;
    end
    else
    begin
      cfg_reg <= cfg_next; // R20
      pat_reg <= pat_next;
    end
  end

  always_comb
  begin
    hit_idx = 3'h0;
    any_hit = 1'b0;
    for (int i = mbc_pkg::NBANK - 1; i >= 0; i--)
      if (f_hit(cfg_reg[i], bus_cmd.addr, bus_cmd.atype))
      begin
        hit_idx = 3'(i); // R21 R1
        any_hit = 1'b1;
      end
  end

  assign bus_ready = state_reg == mbc_pkg::S_IDLE && !ref_req && soft_resetn;
  assign take = bus_req && bus_ready;
  assign pat_cur = pat_reg[ptr_reg];
  assign nbytes = (f_pbytes(scfg_reg.port) < left_reg)
                ? f_pbytes(scfg_reg.port) : left_reg; // R17
  assign beat_end = ((cur_reg[1:0] + nbytes[1:0]) == 2'h0)
                 || left_reg == nbytes;

  // access sequencer
  always_comb
  begin
    state_next = state_reg;
    cmd_next = cmd_reg;
    scfg_next = scfg_reg;
    sel_next = sel_reg;
    cur_next = cur_reg;
    left_next = left_reg;
    wcnt_next = wcnt_reg;
    ptr_next = ptr_reg;
    page_next = page_reg;
    samp_next = 1'b0;
    send_next = send_reg;
    sa_next = sa_reg;
    sn_next = sn_reg;
    err_next = 1'b0;
    ref_done = 1'b0;
    sub_done = 1'b0;
    case (state_reg)
      mbc_pkg::S_IDLE:
        if (ref_req)
        begin
          state_next = mbc_pkg::S_REF; // R13
          ptr_next = mbc_pkg::PAT_REF;
        end
        else if (take && !any_hit)
          err_next = 1'b1; // R5
        else if (take)
        begin
          cmd_next = bus_cmd;
          if (endian == mbc_pkg::END_MOD)
            cmd_next.addr[1:0] = bus_cmd.addr[1:0]
              ^ ((bus_cmd.size == mbc_pkg::SIZE_BYTE) ? 2'h3
              : (bus_cmd.size == mbc_pkg::SIZE_HALF) ? 2'h2 : 2'h0); // R18
          cur_next = cmd_next.addr;
          scfg_next = cfg_reg[hit_idx];
          sel_next = hit_idx;
          left_next = bus_cmd.burst ? mbc_pkg::BURST_BYTES
                    : 5'h01 << bus_cmd.size;
          page_next = 1'b0;
          state_next = mbc_pkg::S_SETUP;
        end
      mbc_pkg::S_SETUP, mbc_pkg::S_WAIT:
      begin
        wcnt_next = (state_reg == mbc_pkg::S_SETUP)
                  ? scfg_reg.waits : wcnt_reg - 4'h1;
        if ((state_reg == mbc_pkg::S_SETUP && scfg_reg.waits != 4'h0)
            || (state_reg == mbc_pkg::S_WAIT && wcnt_reg != 4'h1))
          state_next = mbc_pkg::S_WAIT; // R4
        else if (scfg_reg.dram)
        begin
          state_next = mbc_pkg::S_DRAM;
          ptr_next = page_reg ? mbc_pkg::PAT_PAGE : mbc_pkg::PAT_SINGLE;
        end
        else
          state_next = mbc_pkg::S_STROBE; // R2
      end
      mbc_pkg::S_STROBE:
        sub_done = 1'b1;
      mbc_pkg::S_DRAM:
      begin
        ptr_next = ptr_reg + 5'h01;
        sub_done = pat_cur.last; // R9
      end
      mbc_pkg::S_REF:
      begin
        ptr_next = ptr_reg + 5'h01;
        if (pat_cur.last)
        begin
          ref_done = 1'b1;
          state_next = mbc_pkg::S_IDLE;
        end
      end
      default:
        state_next = mbc_pkg::S_IDLE;
    endcase
    if (sub_done)
    begin
      samp_next = !cmd_reg.wr;
      sa_next = cur_reg[1:0];
      sn_next = nbytes;
      send_next = beat_end;
      cur_next = cur_reg + {27'h0, nbytes}; // R17
      left_next = left_reg - nbytes;
      page_next = scfg_reg.dram; // R12
      state_next = (left_reg == nbytes) ? mbc_pkg::S_IDLE
                 : mbc_pkg::S_SETUP;
    end
    // refresh may start and finish under soft reset
    if (!soft_resetn && state_next != mbc_pkg::S_REF)
    begin
      state_next = mbc_pkg::S_IDLE; // R20 R14
      samp_next = 1'b0;
    end
  end

  assign wack = sub_done && cmd_reg.wr && beat_end && soft_resetn;
  assign ack_next = samp_reg && send_reg;

  // pins and read assembly
  always_comb
  begin
    addr_next = mem_addr;
    d_o_next = mem_d_o;
    acc_next = bus_rdata;
    cs_n_next = 8'hFF;
    be_n_next = 4'hF;
    oe_n_next = 1'b1;
    we_n_next = 1'b1;
    ras_n_next = 1'b1;
    cas_n_next = 1'b1;
    d_oe_n_next = 1'b1;
    ref_act_next = 1'b0;
    ab = 2'h0;
    bl = 2'h0;
    ml = 2'h0;
    if (state_reg inside {mbc_pkg::S_SETUP, mbc_pkg::S_WAIT,
                          mbc_pkg::S_STROBE, mbc_pkg::S_DRAM})
    begin
      cs_n_next[sel_reg] = 1'b0; // R1
      addr_next = cur_reg;
      d_oe_n_next = !cmd_reg.wr;
      for (int j = 0; j < 4; j++)
        if (5'(j) < nbytes)
        begin
          ab = cur_reg[1:0] + 2'(j);
          bl = f_lane(ab, endian);
          ml = f_mlane(ab, scfg_reg.port, endian);
          be_n_next[ml] = 1'b0; // R6
          if (state_reg == mbc_pkg::S_SETUP)
            d_o_next[8*(3-ml) +: 8] = bus_wdata[8*(3-bl) +: 8]; // R17
        end
      if (scfg_reg.dram)
        ras_n_next = !page_reg; // R12
    end
    if (state_reg == mbc_pkg::S_STROBE)
    begin
      oe_n_next = cmd_reg.wr; // R6
      we_n_next = !cmd_reg.wr;
    end
    if (state_reg == mbc_pkg::S_DRAM)
    begin
      ras_n_next = pat_cur.ras_n && !page_reg; // R12
      cas_n_next = pat_cur.cas_n;
      oe_n_next = pat_cur.strb_n || cmd_reg.wr;
      we_n_next = pat_cur.strb_n || !cmd_reg.wr;
    end
    if (state_reg == mbc_pkg::S_REF)
    begin
      for (int i = 0; i < mbc_pkg::NBANK; i++)
        cs_n_next[i] = !(cfg_reg[i].valid && cfg_reg[i].dram);
      ras_n_next = pat_cur.ras_n; // R13
      cas_n_next = pat_cur.cas_n;
      ref_act_next = 1'b1;
    end
    if (samp_reg)
      for (int j = 0; j < 4; j++)
        if (5'(j) < sn_reg)
        begin
          ab = sa_reg + 2'(j);
          bl = f_lane(ab, endian);
          ml = f_mlane(ab, scfg_reg.port, endian);
          acc_next[8*(3-bl) +: 8] = mem_d_i[8*(3-ml) +: 8]; // R17
        end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      state_reg <= mbc_pkg::S_IDLE;
      cmd_reg <= '0;
      scfg_reg <= mbc_pkg::CFG_RST;
      sel_reg <= 3'h0;
      cur_reg <= 32'h0000_0000;
      left_reg <= 5'h00;
      wcnt_reg <= 4'h0;
      ptr_reg <= 5'h00;
      page_reg <= 1'b0;
      samp_reg <= 1'b0;
      send_reg <= 1'b0;
      sa_reg <= 2'h0;
      sn_reg <= 5'h00;
      ack_reg <= 1'b0;
      err_reg <= 1'b0;
      bus_rdata <= 32'h0000_0000;
      mem_addr <= 32'h0000_0000;
      mem_d_o <= 32'h0000_0000;
      mem_cs_n <= 8'hFF;
      mem_be_n <= 4'hF;
      mem_oe_n <= 1'b1;
      mem_we_n <= 1'b1;
      mem_ras_n <= 1'b1;
      mem_cas_n <= 1'b1;
      mem_d_oe_n <= 1'b1;
      ref_act_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cmd_reg <= cmd_next;
      scfg_reg <= scfg_next;
      sel_reg <= sel_next;
      cur_reg <= cur_next;
      left_reg <= left_next;
      wcnt_reg <= wcnt_next;
      ptr_reg <= ptr_next;
      page_reg <= page_next;
      samp_reg <= samp_next;
      send_reg <= send_next;
      sa_reg <= sa_next;
      sn_reg <= sn_next;
      ack_reg <= ack_next;
      err_reg <= err_next;
      bus_rdata <= acc_next;
      mem_addr <= addr_next;
      mem_d_o <= d_o_next;
      mem_cs_n <= cs_n_next;
      mem_be_n <= be_n_next;
      mem_oe_n <= oe_n_next;
      mem_we_n <= we_n_next;
      mem_ras_n <= ras_n_next;
      mem_cas_n <= cas_n_next;
      mem_d_oe_n <= d_oe_n_next;
      ref_act_reg <= ref_act_next;
    end
  end

  assign bus_ack = ack_reg || wack;
  assign bus_err = err_reg;

  AST_ONE_SELECT: assert property (@(posedge clk) disable iff (!resetn)
    !ref_act_reg |-> $onehot0(~mem_cs_n)) // R21
    else $error("more than one bank selected");
  AST_BOOT_LIVE: assert property (@(posedge clk)
    $past(!resetn) && resetn |-> cfg_reg[0].valid && !cfg_reg[1].valid) // R7
    else $error("boot select not live after reset");
  AST_TWO_CLOCKS: assert property (@(posedge clk)
    disable iff (!resetn || !soft_resetn)
    (mem_cs_n != 8'hFF && $past(mem_cs_n) == 8'hFF && !ref_act_reg)
    |=> mem_cs_n == $past(mem_cs_n)) // R2
    else $error("access shorter than two clocks");
  AST_NO_WAIT: assert property (@(posedge clk)
    disable iff (!resetn || !soft_resetn)
    (state_reg == mbc_pkg::S_SETUP && scfg_reg.waits == 4'h0
     && !scfg_reg.dram) |=> state_reg == mbc_pkg::S_STROBE) // R4
    else $error("wait inserted with zero wait states");
  AST_WAIT_COUNT: assert property (@(posedge clk)
    disable iff (!resetn || !soft_resetn)
    (state_reg == mbc_pkg::S_SETUP && scfg_reg.waits == 4'h3)
    |=> state_reg == mbc_pkg::S_WAIT [*3]
    ##1 state_reg != mbc_pkg::S_WAIT) // R4
    else $error("wrong number of wait states");
  AST_UNMAPPED: assert property (@(posedge clk) disable iff (!resetn)
    (take && !any_hit) |=> bus_err && state_reg == mbc_pkg::S_IDLE) // R5
    else $error("unmapped access not refused");
  AST_PAGE_ROW: assert property (@(posedge clk) disable iff (!resetn)
    (state_reg == mbc_pkg::S_DRAM && page_reg) |=> !mem_ras_n) // R12
    else $error("row closed inside page burst");
  AST_SOFT_KEEP: assert property (@(posedge clk) disable iff (!resetn)
    (!soft_resetn && !cfg_we) |=> cfg_reg[0] == $past(cfg_reg[0])) // R19
    else $error("soft reset altered configuration");
  AST_REF_SOFT: assert property (@(posedge clk) disable iff (!resetn)
    (state_reg == mbc_pkg::S_REF && !pat_cur.last)
    |=> state_reg == mbc_pkg::S_REF) // R14
    else $error("refresh cycle cut short");
endmodule
`default_nettype wire

// ---- mbc_pkg.sv ----
/*
  mbc_pkg: constants and types shared by the memory bank controller.
  Assumes a single 50 MHz bus clock domain.
*/
`default_nettype none
package mbc_pkg;
  localparam int         NBANK        = 8;
  localparam int         PAT_DEPTH    = 32;
  localparam int         BLK_SHIFT    = 15;    // smallest block is 32 KB
  localparam logic [1:0] PORT_8       = 2'h0;
  localparam logic [1:0] PORT_16      = 2'h1;
  localparam logic [1:0] PORT_32      = 2'h2;
  localparam logic [1:0] END_BIG      = 2'h0;
  localparam logic [1:0] END_LITTLE   = 2'h1;
  localparam logic [1:0] END_MOD      = 2'h2;
  localparam logic [1:0] SIZE_BYTE    = 2'h0;
  localparam logic [1:0] SIZE_HALF    = 2'h1;
  localparam logic [3:0] SZ_MAX       = 4'hD;  // 32 KB << 13 = 256 MB
  localparam logic [3:0] SZ_DRAM_MIN  = 4'h1;  // 64 KB
  localparam logic [3:0] SZ_BYTE_ONLY = 4'h2;  // 64 KB and 128 KB
  localparam logic [3:0] SZ_WORD_ONLY = 4'hC;  // 128 MB and 256 MB
  localparam logic [4:0] PAT_SINGLE   = 5'h00;
  localparam logic [4:0] PAT_PAGE     = 5'h08;
  localparam logic [4:0] PAT_REF      = 5'h10;
  localparam logic [4:0] BURST_BYTES  = 5'h10;
  localparam logic [2:0] REF_STACK    = 3'h7;
  localparam logic [16:0] BOOT_BASE   = 17'h00000;
  localparam logic [3:0] BOOT_WAITS   = 4'hF;
  localparam int         MIN_ACCESS   = 2;     // clocks of a zero-wait access

  typedef struct packed {
    logic        valid;
    logic [16:0] base;
    logic [3:0]  size;
    logic [3:0]  waits;
    logic        atype_en;
    logic [2:0]  atype;
    logic [1:0]  port;
    logic        dram;
  } mbc_bank_cfg_t;

  typedef struct packed {
    logic ras_n;
    logic cas_n;
    logic strb_n;
    logic last;
  } mbc_pat_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [2:0]  atype;
    logic        wr;
    logic [1:0]  size;
    logic        burst;
  } mbc_bus_req_t;

  typedef enum logic [2:0] {
    S_IDLE, S_SETUP, S_WAIT, S_STROBE, S_DRAM, S_REF
  } mbc_state_t;

  localparam mbc_bank_cfg_t CFG_RST = '0;
  localparam mbc_pat_t      PAT_RST = 4'hF;
endpackage
`default_nettype wire

// ---- mbc_refresh_timer.sv ----
/*
  mbc_refresh_timer: periodic refresh request generator with a stack of
  pending refreshes. Assumes ref_done pulses once per refresh performed.
*/
`timescale 1ns/1ns
`default_nettype none
module mbc_refresh_timer (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        ref_en,
  input  wire logic [15:0] ref_period,
  input  wire logic        ref_done,
  output logic             ref_req,
  output logic [2:0]       ref_pending
);
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic [2:0]  pend_reg;
  logic [2:0]  pend_next;
  logic        tick;

  always_comb
  begin
    tick = ref_en && (cnt_reg >= ref_period);
    cnt_next = tick ? 16'h0000 : cnt_reg + 16'h0001;
    pend_next = pend_reg;
    if (!ref_en)
    begin
      cnt_next = 16'h0000;
      pend_next = 3'h0; // R15
    end
    else if (tick && !(ref_done && pend_reg != 3'h0))
    begin
      if (pend_reg != mbc_pkg::REF_STACK)
        pend_next = pend_reg + 3'h1; // R16
    end
    else if (!tick && ref_done && pend_reg != 3'h0)
      pend_next = pend_reg - 3'h1;
  end

  // hard reset only, so refresh keeps running through soft reset
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      cnt_reg <= 16'h0000;
      pend_reg <= 3'h0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      pend_reg <= pend_next;
    end
  end

  assign ref_req = ref_en && (pend_reg != 3'h0); // R13 R15
  assign ref_pending = pend_reg;

  AST_STACK_HOLD: assert property (@(posedge clk) disable iff (!resetn)
    (ref_en && pend_reg == 3'h7 && !ref_done) |=> pend_reg == 3'h7) // R16
    else $error("refresh stack lost a pending entry");
  AST_STACK_GROW: assert property (@(posedge clk) disable iff (!resetn)
    (tick && !ref_done && pend_reg < 3'h7)
    |=> pend_reg == $past(pend_reg) + 3'h1) // R16
    else $error("refresh request not stacked");
  AST_REF_OFF: assert property (@(posedge clk) disable iff (!resetn)
    !ref_en |=> ref_pending == 3'h0 && !ref_req) // R15
    else $error("refresh pending while disabled");
endmodule
`default_nettype wire

// ---- mbc_mem_model.sv ----
/*
  mbc_mem_model: synchronous 32-bit static memory behind the pins.
  Assumes registered pins on clk and byte enable 0 on D31..24.
*/
`timescale 1ns/1ns
`default_nettype none
module mbc_mem_model (
  input  wire logic        clk,
  input  wire logic [31:0] addr,
  input  wire logic [7:0]  cs_n,
  input  wire logic [3:0]  be_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic [31:0] d_o,
  input  wire logic        d_oe_n,
  output logic      [31:0] d_i
);
  logic [31:0] mem [0:255];
  logic [31:0] last_q = '0;
  wire         sel = ~&cs_n;
  always_ff @(posedge clk)
  begin
    if (sel && !we_n && !d_oe_n)
    begin
      for (int i = 0; i < 4; i++)
        if (!be_n[i])
          mem[addr[9:2]][8*(3-i)+:8] <= d_o[8*(3-i)+:8];
    end
    if (sel && !oe_n)
      last_q <= mem[addr[9:2]];
  end
  // released bus shows the inverse of the last value
  assign d_i = (sel && !oe_n) ? mem[addr[9:2]] : ~last_q;
endmodule
`default_nettype wire

// ---- memory_bank_controller_tb.sv ----
/*
  memory_bank_controller_tb: directed scenarios for the bank controller.
  Assumes mbc_pkg and a 32-bit static memory model on the pins.
*/
`timescale 1ns/1ns
`default_nettype none
module memory_bank_controller_tb;
  logic clk = 0, resetn = 0, soft_resetn = 1, cfg_we = 0, pat_we = 0;
  logic ref_en = 0, bus_req = 0, er;
  logic [1:0]  boot_port = mbc_pkg::PORT_32, endian = mbc_pkg::END_BIG;
  logic [2:0]  cfg_bank = '0, ref_pending;
  logic [4:0]  pat_addr = '0;
  logic [15:0] ref_period = 16'h0001;
  logic [31:0] bus_wdata = '0, rd, bus_rdata, mem_addr, mem_d_o, mem_d_i;
  logic [7:0]  mem_cs_n;
  logic [3:0]  mem_be_n;
  logic bus_ready, bus_ack, bus_err, mem_oe_n, mem_we_n;
  logic mem_ras_n, mem_cas_n, mem_d_oe_n;
  mbc_pkg::mbc_bank_cfg_t cfg_data = '0;
  mbc_pkg::mbc_pat_t      pat_data = '1;
  mbc_pkg::mbc_bus_req_t  bus_cmd = '0;
  int bad_count = 0, compares = 0, lat;
  always #10 clk = ~clk;
  mbc_memory_bank_controller dut (.clk, .resetn, .soft_resetn, .boot_port,
    .cfg_we, .cfg_bank, .cfg_data, .pat_we, .pat_addr, .pat_data, .endian,
    .ref_en, .ref_period, .bus_req, .bus_cmd, .bus_wdata, .bus_ready,
    .bus_ack, .bus_err, .bus_rdata, .mem_addr, .mem_cs_n, .mem_be_n,
    .mem_oe_n, .mem_we_n, .mem_ras_n, .mem_cas_n, .mem_d_o, .mem_d_oe_n,
    .mem_d_i, .ref_pending);
  mbc_mem_model mem (.clk, .addr(mem_addr), .cs_n(mem_cs_n), .be_n(mem_be_n),
    .oe_n(mem_oe_n), .we_n(mem_we_n), .d_o(mem_d_o),
    .d_oe_n(mem_d_oe_n), .d_i(mem_d_i));
  task automatic finish_test();
    if (bad_count == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic xfer(logic [31:0] a, logic w, logic [1:0] sz,
                      logic [31:0] wd, logic [2:0] at);
    int i;
    i = 0;
    @(negedge clk);
    bus_cmd = '{a, at, w, sz, 1'b0};
    bus_wdata = wd;
    bus_req = 1;
    while (bus_ready !== 1'b1 && i < 200)
    begin
      @(negedge clk);
      i++;
    end
    @(negedge clk);
    bus_req = 0;
    // first cycle after the take counts as one
    lat = 1;
    while (bus_ack !== 1'b1 && bus_err !== 1'b1 && lat < 200)
    begin
      @(negedge clk);
      lat++;
    end
    if (i >= 200 || lat >= 200)
    begin
      bad_count++;
      finish_test();
    end
    rd = bus_rdata;
    er = bus_err;
  endtask
  task automatic cfgw(logic [2:0] b, logic [16:0] base, logic [3:0] w,
                      logic ae, logic [3:0] sz, logic dr);
    @(negedge clk);
    cfg_bank = b;
    cfg_data = '{1'b1, base, sz, w, ae, 3'h5, mbc_pkg::PORT_32, dr};
    cfg_we = 1;
    @(negedge clk);
    cfg_we = 0;
  endtask
  task automatic patw(logic [4:0] a, mbc_pkg::mbc_pat_t p);
    @(negedge clk);
    pat_addr = a;
    pat_data = p;
    pat_we = 1;
    @(negedge clk);
    pat_we = 0;
  endtask
  task automatic t_boot();
    xfer(32'h00000010, 1'b1, 2'h2, 32'h11223344, 3'h0);
    chk("boot_wr_lat", 2 + 15, lat);
    xfer(32'h00000010, 1'b0, 2'h2, 32'h0, 3'h0);
    chk("boot_rd_lat", 4 + 15, lat);
    chk("boot_rd", 32'h11223344, rd);
  endtask
  task automatic t_banks();
    cfgw(3'h1, 17'h08000, 4'h0, 1'b0, 4'h0, 1'b0);
    cfgw(3'h2, 17'h08000, 4'h3, 1'b0, 4'h0, 1'b0);
    cfgw(3'h3, 17'h0C000, 4'h3, 1'b1, 4'h0, 1'b0);
    xfer(32'h40000020, 1'b1, 2'h2, 32'h5A5A0F0F, 3'h0);
    chk("min_wr_lat", 2, lat);
    xfer(32'h40000020, 1'b0, 2'h2, 32'h0, 3'h0);
    chk("low_bank_lat", 4, lat);
    chk("low_bank_rd", 32'h5A5A0F0F, rd);
    xfer(32'h60000020, 1'b0, 2'h2, 32'h0, 3'h5);
    chk("wait3_lat", 4 + 3, lat);
    xfer(32'h60000020, 1'b0, 2'h2, 32'h0, 3'h2);
    chk("atype_miss", 1, er);
    xfer(32'h90000000, 1'b0, 2'h2, 32'h0, 3'h0);
    chk("unmapped", 1, er);
  endtask
  task automatic t_endian();
    for (int e = 0; e < 3; e++)
    begin
      endian = e[1:0];
      xfer(32'h40000030, 1'b1, 2'h2, 32'h11223344, 3'h0);
      xfer(32'h40000030, 1'b1, mbc_pkg::SIZE_BYTE, 32'hAAAAAAAA, 3'h0);
      xfer(32'h40000030, 1'b0, 2'h2, 32'h0, 3'h0);
      chk("byte_lane", e == 0 ? 32'hAA223344 : 32'h112233AA, rd);
    end
  endtask
  task automatic t_dram();
    patw(5'h00, '{1'b0, 1'b1, 1'b1, 1'b0});
    patw(5'h01, '{1'b0, 1'b0, 1'b0, 1'b1});
    cfgw(3'h4, 17'h10000, 4'h0, 1'b0, 4'h3, 1'b1);
    cfgw(3'h5, 17'h14000, 4'h0, 1'b0, 4'h1, 1'b1);
    xfer(32'h80000040, 1'b1, 2'h2, 32'hC3C3A5A5, 3'h0);
    chk("dram_wr_lat", 1 + 2, lat);
    xfer(32'h80000040, 1'b0, 2'h2, 32'h0, 3'h0);
    chk("dram_rd_lat", 3 + 2, lat);
    chk("dram_rd", 32'hC3C3A5A5, rd);
    xfer(32'hA0000000, 1'b0, 2'h2, 32'h0, 3'h0);
    chk("dram_64k_word", 1, er);
  endtask
  task automatic t_refresh();
    int mx, nf, nl;
    logic pr;
    mx = 0;
    nf = 0;
    nl = 0;
    pr = 1;
    patw(5'h10, '{1'b1, 1'b0, 1'b1, 1'b0});
    patw(5'h11, '{1'b0, 1'b0, 1'b1, 1'b1});
    fork
      xfer(32'h00000040, 1'b0, 2'h2, 32'h0, 3'h0);
      begin
        repeat (2) @(negedge clk);
        ref_en = 1;
        repeat (60)
        begin
          @(negedge clk);
          if (ref_pending > mx)
            mx = ref_pending;
          if (pr === 1'b1 && mem_ras_n === 1'b0)
          begin
            nf++;
            chk("cas_first", 0, mem_cas_n);
          end
          pr = mem_ras_n;
        end
      end
    join
    chk("stack_max", 7, mx);
    chk("ref_ran", 1, nf != 0);
    ref_en = 0;
    repeat (4) @(negedge clk);
    chk("stack_clr", 0, ref_pending);
    repeat (40)
    begin
      @(negedge clk);
      if (mem_ras_n !== 1'b1)
        nl++;
    end
    chk("ref_off", 0, nl);
  endtask
  task automatic t_resets();
    int nl;
    nl = 0;
    ref_en = 1;
    soft_resetn = 0;
    repeat (40)
    begin
      @(negedge clk);
      if (mem_ras_n === 1'b0)
        nl++;
    end
    chk("ref_in_reset", 1, nl != 0);
    soft_resetn = 1;
    ref_en = 0;
    repeat (6) @(negedge clk);
    xfer(32'h40000030, 1'b0, 2'h2, 32'h0, 3'h0);
    chk("soft_keep_err", 0, er);
    chk("soft_keep_rd", 32'h112233AA, rd);
    resetn = 0;
    repeat (3) @(negedge clk);
    resetn = 1;
    xfer(32'h40000030, 1'b0, 2'h2, 32'h0, 3'h0);
    chk("hard_clear", 1, er);
  endtask
  initial
  begin
    repeat (20) @(negedge clk);
    resetn = 1;
    t_boot();
    t_banks();
    t_endian();
    t_dram();
    t_refresh();
    t_resets();
    finish_test();
  end
endmodule
`default_nettype wire
